// ==== logic/ase_alarm_status.sv ====
/*
  Alarm status encoder: lamps, active-low alarm output, alarm levels and
  group code on the position outputs, with an AXI4-Lite register slave.
  Assumes synchronous inputs from the motion logic and the PLC side.
*/
// Added by the designer: the AXI4-Lite register port and the address map.
`include "ase_map.svh"

module ase_alarm_status
  import ase_pkg::*;
#(
  parameter int unsigned RES_HOLD_CYCLES = `ASE_RES_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire ase_alarm_t alarm_event_i,
  input wire logic servo_on_req_i,
  input wire logic estop_i,
  input wire logic motor_power_ok_i,
  input wire logic actuator_stopped_i,
  input wire logic [3:0] position_done_i,
  input wire logic alarm_reset_in_i,
  output logic servo_enable_o,
  output logic decel_stop_o,
  output logic servo_on_lamp_o,
  output logic alarm_lamp_o,
  output logic alarm_out_n_o,
  output logic code_bit_w8_o,
  output logic code_bit_w4_o,
  output logic code_bit_w2_o,
  output logic code_bit_w1_o
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  ase_state_t st_reg;
  ase_state_t st_next;
  ase_class_t cls;
  logic [3:0] grp_reg;
  logic [3:0] grp_next;
  logic [11:0] acode_reg;
  logic [11:0] acode_next;
  logic [2:0] pio_reg;
  logic swrst_reg;
  logic hold_done;
  logic servo_reg;
  logic lamp_reg;
  logic outn_reg;
  logic decel_reg;
  logic [3:0] pm_reg;
  logic aw_rdy_reg;
  logic w_rdy_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic ar_rdy_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] stat_word;

  // -----------------------------------------------------------------------
  // Alarm classification and reset qualification
  // -----------------------------------------------------------------------
  ase_alarm_classify u_classify (
    .code_i(alarm_event_i.code),
    .cls_o(cls)
  );

  ase_hold_timer #(
    .HOLD_CYCLES(RES_HOLD_CYCLES)
  ) u_hold (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(alarm_reset_in_i),
    .done_o(hold_done)
  );

  // -----------------------------------------------------------------------
  // Alarm state machine
  // -----------------------------------------------------------------------
  wire new_alm = alarm_event_i.valid;
  wire clear_req = hold_done | swrst_reg;
  wire alarm_act = (st_reg != ASE_NORMAL);

  always_comb begin
    st_next = st_reg;
    grp_next = grp_reg;
    acode_next = acode_reg;
    case (st_reg)
      ASE_NORMAL: begin
        if (new_alm) begin
          st_next = cls.cold ? ASE_COLD : ASE_OPC;
          grp_next = cls.group;
          acode_next = alarm_event_i.code;
        end
      end
      ASE_OPC: begin
        if (new_alm && cls.cold) begin
          st_next = ASE_COLD;
        end else if (clear_req && !new_alm) begin
          st_next = ASE_NORMAL;
        end
      end
      ASE_COLD: begin
        st_next = ASE_COLD;
      end
      default: begin
        st_next = ASE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ASE_NORMAL;
      grp_reg <= 4'h0;
      acode_reg <= 12'h000;
    end else begin
      st_reg <= st_next;
      grp_reg <= grp_next;
      acode_reg <= acode_next;
    end
  end

  // -----------------------------------------------------------------------
  // Servo, lamps, alarm output and position/code outputs
  // -----------------------------------------------------------------------
  // Servo holds through the deceleration, then drops until the alarm clears
  wire servo_next = servo_on_req_i && !estop_i && motor_power_ok_i &&
                    (!alarm_act || (servo_reg && !actuator_stopped_i));
  wire lamp_next = alarm_act || estop_i || !motor_power_ok_i;
  wire code_sel = alarm_act && (pio_reg <= `ASE_PIO_CODE_MAX);
  wire [3:0] pm_next = code_sel ? grp_reg : position_done_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      servo_reg <= 1'b0;
      lamp_reg <= 1'b0;
      outn_reg <= 1'b1;
      decel_reg <= 1'b0;
      pm_reg <= 4'h0;
    end else begin
      servo_reg <= servo_next;
      lamp_reg <= lamp_next;
      outn_reg <= !alarm_act;
      decel_reg <= alarm_act;
      pm_reg <= pm_next;
    end
  end

  // -----------------------------------------------------------------------
  // AXI4-Lite write path
  // -----------------------------------------------------------------------
  wire aw_take = s_axi_awvalid_i && aw_rdy_reg;
  wire w_take = s_axi_wvalid_i && w_rdy_reg;
  wire wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  wire aw_have_next = (aw_have_reg || aw_take) && !wr_go;
  wire w_have_next = (w_have_reg || w_take) && !wr_go;
  wire [7:0] wa = {aw_addr_reg[7:2], 2'b00};
  wire wr_ctrl = wr_go && (wa == `ASE_CTRL_OFS);
  wire wr_ro = (wa == `ASE_STAT_OFS) || (wa == `ASE_CODE_OFS);
  wire wr_hit = (wa == `ASE_CTRL_OFS) || wr_ro;
  wire bvalid_next = wr_go || (bvalid_reg && !s_axi_bready_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_rdy_reg <= 1'b1;
      w_rdy_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ASE_RESP_OKAY;
    end else begin
      aw_rdy_reg <= !aw_have_next;
      w_rdy_reg <= !w_have_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      bvalid_reg <= bvalid_next;
      if (wr_go) begin
        bresp_reg <= wr_hit ? `ASE_RESP_OKAY : `ASE_RESP_SLVERR;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Control register
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pio_reg <= `ASE_PIO_RST;
      swrst_reg <= 1'b0;
    end else begin
      if (wr_ctrl && w_strb_reg[0]) begin
        pio_reg <= w_data_reg[`ASE_PIO_MSB:`ASE_PIO_LSB];
      end
      swrst_reg <= wr_ctrl && w_strb_reg[1] && w_data_reg[`ASE_SWRST_BIT];
    end
  end

  // -----------------------------------------------------------------------
  // AXI4-Lite read path
  // -----------------------------------------------------------------------
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`ASE_ST_ACT] = alarm_act;
    stat_word[`ASE_ST_COLD] = (st_reg == ASE_COLD);
    stat_word[`ASE_ST_GRP_LSB +: 4] = grp_reg;
    stat_word[`ASE_ST_SERVO] = servo_reg;
    stat_word[`ASE_ST_LAMP] = lamp_reg;
    stat_word[`ASE_ST_OUTN] = outn_reg;
  end

  wire ar_take = s_axi_arvalid_i && ar_rdy_reg;
  wire [7:0] ra = {s_axi_araddr_i[7:2], 2'b00};
  wire rd_ctrl = (ra == `ASE_CTRL_OFS);
  wire rd_stat = (ra == `ASE_STAT_OFS);
  wire rd_code = (ra == `ASE_CODE_OFS);
  wire [31:0] ctrl_word = {29'h0000_0000, pio_reg};
  wire [31:0] code_word = {20'h0_0000, acode_reg};
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? stat_word :
                        (rd_code ? code_word : 32'h0000_0000));
  wire rd_hit = rd_ctrl || rd_stat || rd_code;
  wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `ASE_RESP_OKAY;
    end else begin
      ar_rdy_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? `ASE_RESP_OKAY : `ASE_RESP_SLVERR;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign s_axi_awready_o = aw_rdy_reg;
  assign s_axi_wready_o = w_rdy_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = ar_rdy_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign servo_enable_o = servo_reg;
  assign servo_on_lamp_o = servo_reg;
  assign decel_stop_o = decel_reg;
  assign alarm_lamp_o = lamp_reg;
  assign alarm_out_n_o = outn_reg;
  assign code_bit_w8_o = pm_reg[3];
  assign code_bit_w4_o = pm_reg[2];
  assign code_bit_w2_o = pm_reg[1];
  assign code_bit_w1_o = pm_reg[0];

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  servo_lamp_off_a: assert property (
    (estop_i || !motor_power_ok_i || !servo_on_req_i) |=> !servo_on_lamp_o)
    else $error("servo lamp lit without servo");

  alarm_lamp_on_a: assert property (
    (estop_i || !motor_power_ok_i || alarm_act) |=> alarm_lamp_o)
    else $error("alarm lamp dark in alarm condition");

  alarm_out_level_a: assert property (
    alarm_act |=> !alarm_out_n_o) else $error("alarm output not off in alarm");

  alarm_out_idle_a: assert property (
    (st_reg == ASE_NORMAL) && estop_i |=> alarm_out_n_o)
    else $error("alarm output off without alarm");

  cold_sticks_a: assert property (
    (st_reg == ASE_COLD) |=> (st_reg == ASE_COLD)[*3])
    else $error("cold start alarm cleared");

  servo_drop_a: assert property (
    alarm_act && actuator_stopped_i |=> !servo_enable_o && decel_stop_o)
    else $error("servo not dropped after stop");

  sw_clear_a: assert property (
    (st_reg == ASE_OPC) && swrst_reg && !new_alm |=> (st_reg == ASE_NORMAL) ##1 alarm_out_n_o)
    else $error("software reset did not clear");

  code_out_a: assert property (
    code_sel |=> {code_bit_w8_o, code_bit_w4_o, code_bit_w2_o, code_bit_w1_o} == $past(grp_reg))
    else $error("group code not on outputs");

  code_map_a: assert property (
    (st_reg == ASE_NORMAL) && new_alm && (alarm_event_i.code == 12'h0a7) |=> grp_reg == 4'h3)
    else $error("wrong group code latched");

  code_stable_a: assert property (
    alarm_act && $past(alarm_act) |-> $stable(grp_reg))
    else $error("group code changed during alarm");

endmodule

// ==== pkg/ase_map.svh ====
/*
  Constants of the alarm status encoder: register offsets, field positions,
  reset values and timing counts.
  Assumes a 40 MHz system clock and an 8-bit AXI4-Lite byte address.
*/
`ifndef ASE_MAP_SVH
`define ASE_MAP_SVH
// What this block does
// - The servo lamp is lit only while the servo is on, never in stop or power-cut states.
// - The alarm lamp is lit for an active alarm, an emergency stop or a motor power cut.
// - The active-low alarm output is ON from power-up with no alarm and OFF on an alarm.
// - Every alarm is resettable or cold-start level, stops the actuator and drops the servo.
// - A resettable alarm clears on a held reset input or on a software reset.
// - A reset input held for 6 ms or more clears a resettable alarm and restores the alarm output; a cold-start alarm stays.
// - In PIO patterns 0 to 3 the four position outputs carry an alarm group code.
// - Jog and pre-homing position writes give 0010, deceleration command error gives 0011.
// - Unmatched board gives 0100, parameter and position data errors give 0110.
// - Excitation, home sensor and home return timeout errors give 0111.
// - Excess speed gives 1000, supply voltage and overheating alarms give 1001.
// - Deviation, push range and soft limit errors give 1011, servo error gives 1100.
// - Any encoder phase disconnection gives 1101.
// - Processor error gives 1110, nonvolatile memory failures give 1111.

// -----------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------
`define ASE_CTRL_OFS 8'h00
`define ASE_STAT_OFS 8'h04
`define ASE_CODE_OFS 8'h08

// -----------------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------------
`define ASE_PIO_MSB 2
`define ASE_PIO_LSB 0
`define ASE_SWRST_BIT 8
`define ASE_PIO_RST 3'h0
`define ASE_PIO_CODE_MAX 3'h3
`define ASE_ST_ACT 0
`define ASE_ST_COLD 1
`define ASE_ST_GRP_LSB 4
`define ASE_ST_SERVO 8
`define ASE_ST_LAMP 9
`define ASE_ST_OUTN 10
`define ASE_RESP_OKAY 2'b00
`define ASE_RESP_SLVERR 2'b10

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define ASE_CLK_NS 25
`define ASE_RES_HOLD_NS 6000000
`define ASE_RES_HOLD_CYC ((`ASE_RES_HOLD_NS + `ASE_CLK_NS - 1) / `ASE_CLK_NS)

`endif

// ==== pkg/ase_pkg.sv ====
/*
  Types of the alarm status encoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ase_pkg;

  // -----------------------------------------------------------------------
  // Alarm states
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ASE_NORMAL = 3'b001,
    ASE_OPC = 3'b010,
    ASE_COLD = 3'b100
  } ase_state_t;

  // -----------------------------------------------------------------------
  // Alarm event and its class
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [11:0] code;
  } ase_alarm_t;

  typedef struct packed {
    logic [3:0] group;
    logic cold;
  } ase_class_t;

endpackage

// ==== logic/ase_alarm_classify.sv ====
/*
  Maps a twelve-bit alarm code to its four-bit group code and level.
  Assumes codes arrive as the three hex digits of the alarm number.
*/
module ase_alarm_classify
  import ase_pkg::*;
(
  input wire logic [11:0] code_i,
  output ase_class_t cls_o
);

  // -----------------------------------------------------------------------
  // Group code lookup
  // -----------------------------------------------------------------------
  function automatic logic [3:0] group_of(input logic [11:0] c);
    case (c)
      12'h092, 12'h093: group_of = 4'h2;
      12'h0a7: group_of = 4'h3;
      12'h0f4: group_of = 4'h4;
      12'h0a1, 12'h0a2: group_of = 4'h6;
      12'h0b8, 12'h0ba, 12'h0be: group_of = 4'h7;
      12'h0c0: group_of = 4'h8;
      12'h0c9, 12'h0ca, 12'h0cc, 12'h0ce: group_of = 4'h9;
      12'h0d8, 12'h0dc, 12'h0d9: group_of = 4'hb;
      12'h0c1: group_of = 4'hc;
      12'h0e8, 12'h0e9, 12'h0ea: group_of = 4'hd;
      12'h0fa: group_of = 4'he;
      12'h0f5, 12'h0f6, 12'h0f8: group_of = 4'hf;
      default: group_of = 4'h0;
    endcase
  endfunction

  // Board, encoder, processor and memory faults need a power cycle
  wire cold_w = (code_i[11:4] >= 8'h0e);

  assign cls_o.group = group_of(code_i);
  assign cls_o.cold = cold_w;

endmodule

// ==== logic/ase_hold_timer.sv ====
/*
  Qualifies the alarm reset input: one pulse once it has been high for
  HOLD_CYCLES consecutive clocks. Assumes a synchronous input.
*/
`include "ase_map.svh"

module ase_hold_timer #(
  parameter int unsigned HOLD_CYCLES = `ASE_RES_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic done_o
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic done_reg;

  // -----------------------------------------------------------------------
  // Hold counter, saturates so the pulse fires once per assertion
  // -----------------------------------------------------------------------
  wire at_end = (cnt_reg == CW'(HOLD_CYCLES));
  wire last = (cnt_reg == CW'(HOLD_CYCLES - 1));

  assign cnt_next = !level_i ? '0 : (at_end ? cnt_reg : cnt_reg + 1'b1);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= level_i && last;
    end
  end

  assign done_o = done_reg;

  hold_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_reg |-> cnt_reg == CW'(HOLD_CYCLES)) else $error("reset pulse before hold time");

endmodule

// ==== test/ase_plc_model.sv ====
/*
  PLC side model: raises the alarm reset input on request and reads the
  four code outputs while the alarm output is OFF.
  Assumes the clock and synchronous active-low reset of the encoder.
*/
module ase_plc_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic short_i,
  input wire logic [7:0] hold_i,
  input wire logic alarm_out_n_i,
  input wire logic [3:0] bits_i,
  output logic alarm_reset_in_o,
  output logic busy_o,
  output logic [3:0] code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  // ---------------------------------------------------------------------
  // Reset request
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 8'h00;
      busy_o <= 1'b0;
      alarm_reset_in_o <= 1'b0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      alarm_reset_in_o <= 1'b1;
      cnt_reg <= 8'h01;
    end else if (busy_o) begin
      cnt_reg <= cnt_reg + 8'h01;
      if ((cnt_reg >= hold_i && (short_i || alarm_out_n_i)) || cnt_reg == 8'hff) begin
        busy_o <= 1'b0;
        alarm_reset_in_o <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------------
  // Code capture
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      code_o <= 4'h0;
    end else if (!alarm_out_n_i) begin
      code_o <= bits_i;
    end
  end
endmodule

// ==== test/ase_alarm_status_tb_top.sv ====
/*
  Self-checking bench of the alarm status encoder with a PLC model.
  Assumes a 40 MHz clock and a shortened reset hold count.
*/
`include "ase_map.svh"

module ase_alarm_status_tb_top;
  import ase_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  localparam logic [15:0] TBL [25] = '{16'h0922, 16'h0932, 16'h0a73, 16'h0f44, 16'h0a16,
    16'h0a26, 16'h0b87, 16'h0ba7, 16'h0be7, 16'h0c08, 16'h0c99, 16'h0ca9, 16'h0cc9,
    16'h0ce9, 16'h0d8b, 16'h0dcb, 16'h0d9b, 16'h0c1c, 16'h0e8d, 16'h0e9d, 16'h0ead,
    16'h0fae, 16'h0f5f, 16'h0f6f, 16'h0f8f};
  localparam logic [5:0] LMP [5] = '{6'b001001, 6'b101101, 6'b111011, 6'b100011,
    6'b101101};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, pos = 4'h5, bits, plc_code;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, servo_en, decel, sv_lamp, al_lamp, outn;
  logic [1:0] bresp, rresp;
  ase_alarm_t ev = '0;
  logic req = 1'b0, estop = 1'b0, pwr = 1'b1, stopped = 1'b1;
  logic res_in, start = 1'b0, short_hold = 1'b0, busy;
  logic [7:0] hold_c = 8'h00;
  int bad_count = 0, cmp_count = 0, cyc = 0;

  // ---------------------------------------------------------------------
  // Clock, design and partner
  // ---------------------------------------------------------------------
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  ase_alarm_status #(.RES_HOLD_CYCLES(HOLD)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .alarm_event_i(ev),
    .servo_on_req_i(req), .estop_i(estop), .motor_power_ok_i(pwr),
    .actuator_stopped_i(stopped), .position_done_i(pos), .alarm_reset_in_i(res_in),
    .servo_enable_o(servo_en), .decel_stop_o(decel), .servo_on_lamp_o(sv_lamp),
    .alarm_lamp_o(al_lamp), .alarm_out_n_o(outn), .code_bit_w8_o(bits[3]),
    .code_bit_w4_o(bits[2]), .code_bit_w2_o(bits[1]), .code_bit_w1_o(bits[0]));
  ase_plc_model u_plc (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start),
    .short_i(short_hold), .hold_i(hold_c), .alarm_out_n_i(outn), .bits_i(bits),
    .alarm_reset_in_o(res_in), .busy_o(busy), .code_o(plc_code));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic do_reset(input int n);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(1);
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_i);
      ta = ta || awready === 1'b1;
      tw = tw || wready === 1'b1;
      @(posedge clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge clk_i); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk_i);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    while (!t) begin
      @(negedge clk_i);
      t = arready === 1'b1;
      @(posedge clk_i);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge clk_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk_i);
    rready <= 1'b0;
  endtask
  task automatic fire(input logic [11:0] c);
    @(posedge clk_i);
    ev <= {1'b1, c};
    @(posedge clk_i);
    ev <= '0;
    tick(2);
  endtask
  task automatic plc_clear(input logic [7:0] h, input logic sh);
    @(posedge clk_i);
    hold_c <= h;
    short_hold <= sh;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    do @(negedge clk_i); while (busy === 1'b1);
    tick(2);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset_map();
    logic [31:0] d;
    logic [1:0] r;
    chk(outn, 1'b1);
    chk(bits, 4'h5);
    axi_read(`ASE_CTRL_OFS, d, r);
    chk(d, 32'h0);
    axi_read(8'h0c, d, r);
    chk({d, r}, {32'h0, `ASE_RESP_SLVERR});
    axi_write(8'h0c, 32'h1, 4'hf, r);
    chk(r, `ASE_RESP_SLVERR);
  endtask
  task automatic t_lamps();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      {req, estop, pwr} <= LMP[i][5:3];
      tick(3);
      chk(sv_lamp, LMP[i][2]);
      chk(al_lamp, LMP[i][1]);
      chk(outn, LMP[i][0]);
    end
  endtask
  task automatic t_codes();
    logic [31:0] d;
    logic [1:0] r;
    logic [11:0] c;
    logic [3:0] g;
    logic cold;
    for (int i = 0; i < 25; i++) begin
      c = TBL[i][15:4];
      g = TBL[i][3:0];
      cold = c >= 12'h0e0;
      fire(c);
      chk(bits, g);
      chk({outn, al_lamp, decel}, 3'b011);
      @(posedge clk_i);
      pos <= 4'ha;
      tick(3);
      chk({bits, sv_lamp, plc_code}, {g, 1'b0, g});
      axi_read(`ASE_STAT_OFS, d, r);
      chk(d, {21'h0, 3'b010, g, 2'b00, cold, 1'b1});
      axi_read(`ASE_CODE_OFS, d, r);
      chk(d, {20'h0, c});
      plc_clear(HOLD, 1'b0);
      chk(outn, !cold);
      if (cold) do_reset(2);
      chk({outn, bits}, {1'b1, 4'ha});
      @(posedge clk_i);
      pos <= 4'h5;
    end
  endtask
  task automatic t_hold();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    stopped <= 1'b0;
    fire(12'h0a7);
    chk({sv_lamp, servo_en}, 2'b11);
    @(posedge clk_i);
    stopped <= 1'b1;
    tick(2);
    chk({sv_lamp, servo_en}, 2'b00);
    plc_clear(HOLD - 1, 1'b1);
    chk(outn, 1'b0);
    plc_clear(3 * HOLD, 1'b0);
    chk(outn, 1'b1);
    fire(12'h0a7);
    fire(12'h0e8);
    axi_read(`ASE_STAT_OFS, d, r);
    chk(d, {21'h0, 3'b010, 4'h3, 2'b00, 2'b11});
    axi_read(`ASE_CODE_OFS, d, r);
    chk(d, 32'h0a7);
    do_reset(2);
  endtask
  task automatic t_sw_pio();
    logic [31:0] d;
    logic [1:0] r;
    fire(12'h0a1);
    axi_write(`ASE_CTRL_OFS, 32'h100, 4'h2, r);
    tick(3);
    chk({r, outn}, {`ASE_RESP_OKAY, 1'b1});
    for (int p = 1; p < 5; p++) begin
      axi_write(`ASE_CTRL_OFS, p, 4'h1, r);
      fire(12'h0c1);
      chk(bits, (p < 4) ? 4'hc : 4'h5);
      plc_clear(HOLD, 1'b0);
    end
    axi_read(`ASE_CTRL_OFS, d, r);
    chk(d, 32'h4);
    axi_write(`ASE_CTRL_OFS, 32'h0, 4'h1, r);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(2);
    t_reset_map();
    t_lamps();
    t_codes();
    t_hold();
    t_sw_pio();
    give_verdict();
  end
endmodule
